// ### design/serial_pkg.sv
/*
 * Shared constants, types and helpers for the dual serial channel block.
 * Assumes a single 100 MHz core clock and a synchronous active-high reset.
 */
package serial_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;

	// system clock divided by four feeds the prescaler
	localparam logic [1:0] PHI_DIV_LAST = 2'h3;
	localparam int         PRE_W        = 6;

	// byte offsets inside one channel window; address bit 5 picks the channel
	localparam logic [4:0] OFF_MODE      = 5'h00;
	localparam logic [4:0] OFF_BAUD_CTRL = 5'h04;
	localparam logic [4:0] OFF_BAUD_FRAC = 5'h08;
	localparam logic [4:0] OFF_TX        = 5'h0c;
	localparam logic [4:0] OFF_RX        = 5'h10;
	localparam logic [4:0] OFF_STAT      = 5'h14;
	localparam int         CH_SEL_BIT    = 5;

	// mode register fields
	localparam int MODE_LSB = 0;
	localparam int PAR_EN   = 2;
	localparam int PAR_ODD  = 3;
	localparam int WAKE_EN  = 4;
	localparam int RX_EN    = 5;
	localparam int BRG_EN   = 6;

	// baud control fields
	localparam int N_LSB   = 0;
	localparam int TAP_LSB = 4;
	localparam int FE_BIT  = 6;

	// status bits
	localparam int ST_BUSY = 0;
	localparam int ST_FULL = 1;
	localparam int ST_OVR  = 2;
	localparam int ST_PERR = 3;
	localparam int ST_FERR = 4;
	localparam int ST_B8   = 5;

	// 16 sample clocks per bit, votes on the 7th, 8th and 9th
	localparam logic [3:0] VOTE_FIRST = 4'h6;
	localparam logic [3:0] VOTE_LAST  = 4'h8;
	localparam logic [3:0] BIT_LAST   = 4'hf;
	localparam logic [3:0] SYNC_BITS  = 4'h8;
	localparam logic [4:0] FRAC_ONE   = 5'h10;

	typedef enum logic [1:0] {
		SYNC_IO = 2'b00,
		UART7   = 2'b01,
		UART8   = 2'b10,
		UART9   = 2'b11
	} mode_e;

	typedef struct packed {
		logic [7:0]  mode;
		logic [6:0]  bctl;
		logic [3:0]  k;
		logic        tx_busy;
		logic [11:0] tx_sh;
		logic [3:0]  tx_left;
		logic [3:0]  tx_tc;
		logic        sclk;
		logic        rx_act;
		logic [9:0]  rx_sh;
		logic [3:0]  rx_left;
		logic [3:0]  rx_tc;
		logic [1:0]  ones;
		logic [8:0]  rx_data;
		logic        full;
		logic        ovr;
		logic        perr;
		logic        ferr;
		logic [2:0]  sy;
		logic        rxf;
	} chan_s;

	localparam chan_s CHAN_RST = '{
		mode: 8'h00, bctl: 7'h00, k: 4'h0, tx_busy: 1'b0, tx_sh: 12'hfff,
		tx_left: 4'h0, tx_tc: 4'h0, sclk: 1'b1, rx_act: 1'b0, rx_sh: 10'h000,
		rx_left: 4'h0, rx_tc: 4'h0, ones: 2'h0, rx_data: 9'h000, full: 1'b0,
		ovr: 1'b0, perr: 1'b0, ferr: 1'b0, sy: 3'h7, rxf: 1'b1};

	function automatic logic [3:0] data_bits(input logic [1:0] m);
		unique case (m)
			UART7:   data_bits = 4'h7;
			UART9:   data_bits = 4'h9;
			default: data_bits = 4'h8;
		endcase
	endfunction

	// parity only in the 7 and 8 bit frames
	function automatic logic par_on(input logic [7:0] mode);
		par_on = mode[PAR_EN] & (mode[1:0] == UART7 || mode[1:0] == UART8);
	endfunction

	function automatic logic par_of(input logic [8:0] d, input logic [3:0] nb, input logic odd);
		par_of = (^(d & ~(9'h1ff << nb))) ^ odd;
	endfunction
endpackage

// ### design/brg_if.sv
/*
 * Link between the channel logic and its baud rate generator.
 * Assumes tap strobes are one-cycle pulses on the core clock.
 */
interface brg_if;
	logic [3:0] taps;
	logic [1:0] tap_sel;
	logic [3:0] n;
	logic       frac_en;
	logic [3:0] k;
	logic       sync_mode;
	logic       tick;
	logic       mid;

	modport gen (input taps, tap_sel, n, frac_en, k, sync_mode, output tick, mid);
	modport user (output taps, tap_sel, n, frac_en, k, sync_mode, input tick, mid);
endinterface

// ### design/prescaler_taps.sv
/*
 * Shared 6-bit prescaler producing four tap strobes (divide by 1, 4, 16, 64
 * of the system clock divided by four). Assumes core_clk domain only.
 */
module prescaler_taps (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       run,
	output logic [3:0]      taps
);
	typedef struct packed {
		logic [1:0]                      q;
		logic [serial_pkg::PRE_W-1:0]    pre;
		logic [3:0]                      taps;
	} pre_s;

	pre_s r;
	pre_s n;
	logic base;

	always_comb begin
		n = r;
		base = run & (r.q == serial_pkg::PHI_DIV_LAST);
		n.taps = '0;
		if (run) begin
			n.q = r.q + 2'h1;
		end
		if (base) begin
			n.pre = r.pre + 6'h01;
			n.taps[0] = 1'b1;
			n.taps[1] = (r.pre[1:0] == 2'h3);
			n.taps[2] = (r.pre[3:0] == 4'hf);
			n.taps[3] = (r.pre == 6'h3f);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else if (clk_en) begin
			r <= n;
		end
	end

	assign taps = r.taps;
endmodule

// ### design/baud_rate_gen.sv
/*
 * Baud rate divider: integer N or, outside sync mode, fractional N+(16-K)/16 of a selected tap.
 * Assumes tap strobes from the shared prescaler on the same clock.
 */
module baud_rate_gen (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	brg_if.gen        b
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [3:0] acc;
		logic       stretch;
	} bg_s;

	bg_s        r;
	bg_s        n;
	logic       tick_c;
	logic       mid_c;
	logic       fe;
	logic [4:0] len;
	logic [4:0] cn;
	logic [4:0] sum;

	always_comb begin
		n = r;
		tick_c = 1'b0;
		mid_c = 1'b0;
		fe = b.frac_en & ~b.sync_mode;
		len = ((b.n == 4'h0) ? 5'h10 : {1'b0, b.n}) + {4'h0, r.stretch};
		cn = r.cnt + 5'h01;
		sum = {1'b0, r.acc} + (serial_pkg::FRAC_ONE - {1'b0, b.k});
		if (b.taps[b.tap_sel]) begin
			mid_c = (cn == (len >> 1));
			if (cn >= len) begin
				tick_c = 1'b1;
				n.cnt = 5'h00;
				n.stretch = fe & sum[4];
				n.acc = fe ? sum[3:0] : 4'h0;
			end else begin
				n.cnt = cn;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else if (clk_en) begin
			r <= n;
		end
	end

	assign b.tick = tick_c;
	assign b.mid = mid_c;
endmodule

// ### design/serial_channel_baud_generator.sv
/*
 * Two serial channels (UART 7/8/9 bit or synchronous shift I/O) with a
 * shared prescaler and one baud rate generator each, on an Avalon-MM slave.
 * Assumes the serial pins are asynchronous to core_clk; the shift clock pin
 * is driven only in synchronous mode.
 */
// The implementer's own choices: the address map and register access over Avalon-MM.
// How it works
// - two channels, 0 and 1, identical and independent apart from their pins and the shared prescaler
// - each channel runs as UART or as synchronous shift-clock I/O
// - UART frame: start, 7, 8 or 9 data bits LSB first, stop
// - optional parity after data in 7 and 8 bit modes, never in 9 bit
// - ninth bit 1 marks address, 0 marks data
// - 9 bit mode wake-up lets a master address slaves on one link
// - 6-bit prescaler fed by system clock divided by four
// - prescaler runs while the baud generator is the transfer clock
// - two-bit field picks tap divide by 1, 4, 16 or 64
// - fraction off: fraction ignored, divide by integer N 1 to 16
// - fraction on: divide by N plus (16 minus K) sixteenths; sync mode keeps integer N
// - UART bit rate is generator output divided by a further 16
// - synchronous rate equals generator output, no extra divide
// - UART bit spans 16 samples, majority of 7th, 8th, 9th
module serial_channel_baud_generator (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [1:0]       ser_tx_pin,
	input  wire logic [1:0]  ser_rx_pin,
	output logic [1:0]       ser_shift_clk_pin_out,
	output logic [1:0]       ser_shift_clk_pin_oe
);
	typedef struct packed {
		serial_pkg::chan_s [1:0] ch;
		logic                    ack;
		logic [31:0]             rdata;
	} state_s;

	state_s     r;
	state_s     n;
	logic       req;
	logic [3:0] taps;
	logic [1:0] tick;
	logic [1:0] mid;
	logic       run;

	// register read image of one channel
	function automatic logic [31:0] rd_word(input serial_pkg::chan_s c, input logic [4:0] off);
		unique case (off)
			serial_pkg::OFF_MODE:      rd_word = {24'h0, c.mode};
			serial_pkg::OFF_BAUD_CTRL: rd_word = {25'h0, c.bctl};
			serial_pkg::OFF_BAUD_FRAC: rd_word = {28'h0, c.k};
			serial_pkg::OFF_RX:        rd_word = {23'h0, c.rx_data};
			serial_pkg::OFF_STAT:      rd_word = {26'h0, c.rx_data[8], c.ferr, c.perr, c.ovr, c.full, c.tx_busy};
			default:                   rd_word = 32'h0;
		endcase
	endfunction

	// hand a received word to software; old word kept on overrun
	function automatic serial_pkg::chan_s deliver(
		input serial_pkg::chan_s c,
		input logic [8:0]        dat,
		input logic              pe,
		input logic              fe
	);
		deliver = c;
		if (c.full) begin
			deliver.ovr = 1'b1;
		end else begin
			deliver.rx_data = dat;
			deliver.full = 1'b1;
			deliver.perr = pe;
			deliver.ferr = fe;
		end
	endfunction

	// majority of three samples
	function automatic logic vote(input logic [1:0] ones, input logic cur);
		vote = ({1'b0, ones} + {2'b00, cur}) >= 3'h2;
	endfunction

	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~r.ack;
	assign avs_readdata = r.rdata;
	assign run = r.ch[0].mode[serial_pkg::BRG_EN] | r.ch[1].mode[serial_pkg::BRG_EN];

	prescaler_taps u_pre (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.run      (run),
		.taps     (taps)
	);

	for (genvar g = 0; g < 2; g++) begin : g_ch
		brg_if b ();

		assign b.taps = taps;
		assign b.tap_sel = r.ch[g].bctl[serial_pkg::TAP_LSB +: 2];
		assign b.n = r.ch[g].bctl[serial_pkg::N_LSB +: 4];
		assign b.frac_en = r.ch[g].bctl[serial_pkg::FE_BIT];
		assign b.k = r.ch[g].k;
		assign b.sync_mode = (r.ch[g].mode[1:0] == serial_pkg::SYNC_IO);
		// generator output is masked unless it is the chosen transfer clock
		assign tick[g] = b.tick & r.ch[g].mode[serial_pkg::BRG_EN];
		assign mid[g] = b.mid & r.ch[g].mode[serial_pkg::BRG_EN];

		baud_rate_gen u_bg (
			.core_clk (core_clk),
			.rst      (rst),
			.clk_en   (clk_en),
			.b        (b)
		);

		assign ser_tx_pin[g] = r.ch[g].tx_sh[0];
		assign ser_shift_clk_pin_out[g] = r.ch[g].sclk;
		assign ser_shift_clk_pin_oe[g] = b.sync_mode;
	end

	always_comb begin
		logic        wr;
		logic        rd;
		logic        sync;
		logic [3:0]  d;
		logic        p;
		logic [3:0]  total;
		logic [11:0] fr;
		logic [9:0]  w;
		logic        bv;
		logic [4:0]  off;
		wr = 1'b0;
		rd = 1'b0;
		sync = 1'b0;
		d = 4'h0;
		p = 1'b0;
		total = 4'h0;
		fr = 12'h0;
		w = 10'h0;
		bv = 1'b0;
		off = avs_address[4:0];
		n = r;
		n.ack = req & ~r.ack;
		// read data only moves when a read is taken
		if (avs_read & ~r.ack) begin
			n.rdata = rd_word(r.ch[avs_address[serial_pkg::CH_SEL_BIT]], off);
		end
		for (int c = 0; c < 2; c++) begin
			wr = r.ack & avs_write & (avs_address[serial_pkg::CH_SEL_BIT] == 1'(c));
			rd = r.ack & avs_read & (avs_address[serial_pkg::CH_SEL_BIT] == 1'(c));
			sync = (r.ch[c].mode[1:0] == serial_pkg::SYNC_IO);
			d = serial_pkg::data_bits(r.ch[c].mode[1:0]);
			p = serial_pkg::par_on(r.ch[c].mode);
			total = d + {3'h0, p} + 4'h2;

			// pin synchroniser and agreement filter
			n.ch[c].sy = {r.ch[c].sy[1:0], ser_rx_pin[c]};
			if (r.ch[c].sy[1] == r.ch[c].sy[2]) begin
				n.ch[c].rxf = r.ch[c].sy[2];
			end

			if (rd && off == serial_pkg::OFF_RX) begin
				n.ch[c].full = 1'b0;
			end
			if (wr) begin
				unique case (off)
					serial_pkg::OFF_MODE:      n.ch[c].mode = avs_writedata[7:0];
					serial_pkg::OFF_BAUD_CTRL: n.ch[c].bctl = avs_writedata[6:0];
					serial_pkg::OFF_BAUD_FRAC: n.ch[c].k = avs_writedata[3:0];
					serial_pkg::OFF_STAT: begin
						n.ch[c].ovr = r.ch[c].ovr & ~avs_writedata[serial_pkg::ST_OVR];
						n.ch[c].perr = r.ch[c].perr & ~avs_writedata[serial_pkg::ST_PERR];
						n.ch[c].ferr = r.ch[c].ferr & ~avs_writedata[serial_pkg::ST_FERR];
					end
					serial_pkg::OFF_TX: begin
						if (!r.ch[c].tx_busy) begin
							n.ch[c].tx_busy = 1'b1;
							n.ch[c].tx_tc = 4'h0;
							if (sync) begin
								n.ch[c].tx_sh = {4'hf, avs_writedata[7:0]};
								n.ch[c].tx_left = serial_pkg::SYNC_BITS;
								n.ch[c].rx_sh = 10'h000;
							end else begin
								// stop and idle ones above data and parity
								fr = 12'hfff << (d + {3'h0, p});
								fr = fr | ({3'h0, avs_writedata[8:0]} & ~(12'hfff << d));
								if (p) begin
									fr[d] = serial_pkg::par_of(avs_writedata[8:0], d,
										r.ch[c].mode[serial_pkg::PAR_ODD]);
								end
								// idle lead bit holds the pin until the next tick, so the start bit is whole
								n.ch[c].tx_sh = {fr[9:0], 2'b01};
								n.ch[c].tx_left = total + 4'h1;
								n.ch[c].tx_tc = serial_pkg::BIT_LAST;
							end
						end
					end
					default: ;
				endcase
			end

			if (sync) begin
				n.ch[c].rx_act = 1'b0;
				if (r.ch[c].tx_busy && tick[c]) begin
					if (r.ch[c].tx_tc == 4'h0) begin
						n.ch[c].tx_tc = 4'h1;
						n.ch[c].sclk = 1'b0;
					end else begin
						n.ch[c].tx_sh = {1'b1, r.ch[c].tx_sh[11:1]};
						n.ch[c].tx_left = r.ch[c].tx_left - 4'h1;
						if (r.ch[c].tx_left == 4'h1) begin
							n.ch[c].tx_busy = 1'b0;
							if (r.ch[c].mode[serial_pkg::RX_EN]) begin
								n.ch[c] = deliver(n.ch[c], {1'b0, r.ch[c].rx_sh[9:2]}, 1'b0, 1'b0);
							end
						end else begin
							n.ch[c].sclk = 1'b0;
						end
					end
				end
				// receive on the rising shift clock
				if (r.ch[c].tx_busy && mid[c] && !r.ch[c].sclk) begin
					n.ch[c].sclk = 1'b1;
					n.ch[c].rx_sh = {r.ch[c].rxf, r.ch[c].rx_sh[9:1]};
				end
			end else begin
				n.ch[c].sclk = 1'b1;
				if (r.ch[c].tx_busy && tick[c]) begin
					n.ch[c].tx_tc = r.ch[c].tx_tc + 4'h1;
					if (r.ch[c].tx_tc == serial_pkg::BIT_LAST) begin
						n.ch[c].tx_sh = {1'b1, r.ch[c].tx_sh[11:1]};
						n.ch[c].tx_left = r.ch[c].tx_left - 4'h1;
						n.ch[c].tx_busy = (r.ch[c].tx_left != 4'h1);
					end
				end

				if (!r.ch[c].mode[serial_pkg::RX_EN]) begin
					n.ch[c].rx_act = 1'b0;
				end else if (tick[c]) begin
					if (!r.ch[c].rx_act) begin
						if (!r.ch[c].rxf) begin
							n.ch[c].rx_act = 1'b1;
							n.ch[c].rx_tc = 4'h1;
							n.ch[c].ones = 2'h0;
							n.ch[c].rx_left = total;
						end
					end else begin
						n.ch[c].rx_tc = r.ch[c].rx_tc + 4'h1;
						if (r.ch[c].rx_tc >= serial_pkg::VOTE_FIRST && r.ch[c].rx_tc < serial_pkg::VOTE_LAST) begin
							n.ch[c].ones = r.ch[c].ones + {1'b0, r.ch[c].rxf};
						end
						if (r.ch[c].rx_tc == serial_pkg::VOTE_LAST) begin
							bv = vote(r.ch[c].ones, r.ch[c].rxf);
							n.ch[c].ones = 2'h0;
							n.ch[c].rx_left = r.ch[c].rx_left - 4'h1;
							if (r.ch[c].rx_left == total) begin
								// start bit that votes high is a glitch
								n.ch[c].rx_act = ~bv;
							end else if (r.ch[c].rx_left == 4'h1) begin
								n.ch[c].rx_act = 1'b0;
								w = r.ch[c].rx_sh >> (4'ha - d - {3'h0, p});
								// wake-up: only address frames pass
								if (!(r.ch[c].mode[serial_pkg::WAKE_EN] && r.ch[c].mode[1:0] == serial_pkg::UART9)
									|| w[8]) begin
									n.ch[c] = deliver(n.ch[c], w[8:0] & ~(9'h1ff << (d + {3'h0, p})),
										p & (w[d] != serial_pkg::par_of(w[8:0], d,
										r.ch[c].mode[serial_pkg::PAR_ODD])), ~bv);
								end
							end else begin
								n.ch[c].rx_sh = {bv, r.ch[c].rx_sh[9:1]};
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r.ch <= {serial_pkg::CHAN_RST, serial_pkg::CHAN_RST};
			r.ack <= 1'b0;
			r.rdata <= 32'h0;
		end else if (clk_en) begin
			r <= n;
		end
	end
endmodule

// ### testbench/serial_channel_baud_generator_chk.sv
/*
 * Port-level checks on the dual serial block.
 * Assumes clk_en held high and rate settings changed only between frames.
 */
module serial_channel_baud_generator_chk (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  ser_tx_pin,
	input wire logic [1:0]  ser_shift_clk_pin_oe
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic [1:0] m0_reg;
	logic [1:0] m1_reg;
	logic [6:0] bc_reg;
	logic [3:0] k_reg;
	logic       prev_reg;
	int         cnt_reg;
	int         nv;
	int         bit_len;
	logic       wr;
	assign wr = avs_write && !avs_waitrequest && clk_en;
	assign nv = (bc_reg[3:0] == 4'h0) ? 16 : int'(bc_reg[3:0]);
	assign bit_len = (4 << (2 * bc_reg[5:4])) * (16 * nv + (bc_reg[6] ? 16 - int'(k_reg) : 0));
	// length of the last level run on channel 0 tx
	always_ff @(posedge core_clk) begin
		prev_reg <= rst ? 1'b1 : ser_tx_pin[0];
		cnt_reg <= (rst || ser_tx_pin[0] != prev_reg) ? 1 : cnt_reg + 1;
		if (rst) begin
			m0_reg <= 2'h0;
			m1_reg <= 2'h0;
			bc_reg <= 7'h00;
			k_reg <= 4'h0;
		end else if (wr) begin
			if (avs_address == 6'h00) m0_reg <= avs_writedata[1:0];
			if (avs_address == 6'h20) m1_reg <= avs_writedata[1:0];
			if (avs_address == 6'h04) bc_reg <= avs_writedata[6:0];
			if (avs_address == 6'h08) k_reg <= avs_writedata[3:0];
		end
	end
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high with no request");
	a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	a_rd_unmapped: assert property (avs_read && !avs_waitrequest && avs_address[4:0] > 5'h14 |-> avs_readdata == 32'h0)
		else $error("unmapped offset read not zero");
	a_tx_reset: assert property ($fell(rst) |-> ser_tx_pin == 2'h3 && avs_readdata == 32'h0)
		else $error("tx or read data wrong after reset");
	a_oe_ch0: assert property (ser_shift_clk_pin_oe[0] == (m0_reg == 2'h0))
		else $error("channel 0 shift clock enable disagrees with mode");
	a_oe_ch1: assert property (ser_shift_clk_pin_oe[1] == (m1_reg == 2'h0))
		else $error("channel 1 shift clock enable disagrees with mode");
	a_bit_len: assert property (m0_reg != 2'h0 && ser_tx_pin[0] && !prev_reg |-> cnt_reg % bit_len == 0)
		else $error("uart low run not a whole number of bit times");
endmodule

bind serial_channel_baud_generator serial_channel_baud_generator_chk u_chk (
	.core_clk             (core_clk),
	.rst                  (rst),
	.clk_en               (clk_en),
	.avs_address          (avs_address),
	.avs_read             (avs_read),
	.avs_write            (avs_write),
	.avs_writedata        (avs_writedata),
	.avs_readdata         (avs_readdata),
	.avs_waitrequest      (avs_waitrequest),
	.ser_tx_pin           (ser_tx_pin),
	.ser_shift_clk_pin_oe (ser_shift_clk_pin_oe)
);

// ### testbench/uart_far_end.sv
/*
 * Far-end serial peer: decodes uart frames, sends frames, shifts sync data.
 * Assumes one instance per channel on the core clock.
 */
module uart_far_end (
	input  wire logic core_clk,
	input  wire logic tx,
	input  wire logic sclk,
	input  wire logic sclk_oe,
	output logic      rx
);
	timeunit 1ns;
	timeprecision 1ns;
	int         bit_len = 64;
	int         nbits   = 9;
	int         start_len;
	int         n_got   = 0;
	int         n_fall  = 0;
	time        t_first;
	time        t_last;
	logic [9:0] got;
	logic [7:0] sy_in;
	logic [7:0] sy_out;
	initial rx = 1'b1;
	// bit spacing taken from the measured start bit
	always @(negedge tx) if (!sclk_oe) begin
		start_len = 0;
		got = 10'h000;
		@(negedge core_clk);
		while (!tx) begin
			start_len++;
			@(negedge core_clk);
		end
		repeat (start_len / 2 - 1) @(negedge core_clk);
		for (int i = 0; i < nbits; i++) begin
			if (i > 0) repeat (start_len) @(negedge core_clk);
			got[i] = tx;
		end
		n_got++;
	end
	always @(posedge sclk) if (sclk_oe) sy_in <= {tx, sy_in[7:1]};
	always @(negedge sclk) if (sclk_oe) begin
		rx <= sy_out[n_fall];
		n_fall++;
		t_last = $time;
		if (n_fall == 1) t_first = $time;
	end
	task automatic send(input logic [10:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			rx <= w[i];
			repeat (bit_len) @(posedge core_clk);
		end
		rx <= 1'b1;
	endtask
endmodule

// ### testbench/serial_channel_baud_generator_bench.sv
/*
 * Self-checking bench: uart frames and rates, receive, wake-up, shift mode.
 * Assumes one far-end peer per channel and clk_en held high.
 */
module serial_channel_baud_generator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk      = 1'b0;
	logic        rst           = 1'b1;
	logic        clk_en        = 1'b1;
	logic [5:0]  avs_address   = 6'h00;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	wire  [1:0]  ser_tx_pin;
	wire  [1:0]  ser_rx_pin;
	wire  [1:0]  sclk_out;
	wire  [1:0]  sclk_oe;
	logic [31:0] q;
	int          bad_count  = 0;
	int          n_compared = 0;
	int          exp_q [$];
	logic [5:0]  ra [6] = '{6'h00, 6'h04, 6'h08, 6'h14, 6'h34, 6'h38};
	int          cfg [7][7] = '{'{2, 0, 0, 1, 0, 0, 0}, '{1, 1, 0, 2, 1, 0, 0}, '{2, 1, 1, 0, 0, 0, 0},
		'{3, 1, 0, 7, 0, 1, 3}, '{1, 0, 0, 2, 0, 1, 15}, '{2, 0, 0, 1, 2, 0, 0}, '{2, 0, 0, 1, 3, 0, 0}};
	always #5 core_clk = ~core_clk;
	serial_channel_baud_generator u_serial_channel_baud_generator (
		.core_clk              (core_clk),
		.rst                   (rst),
		.clk_en                (clk_en),
		.avs_address           (avs_address),
		.avs_read              (avs_read),
		.avs_write             (avs_write),
		.avs_writedata         (avs_writedata),
		.avs_readdata          (avs_readdata),
		.avs_waitrequest       (avs_waitrequest),
		.ser_tx_pin            (ser_tx_pin),
		.ser_rx_pin            (ser_rx_pin),
		.ser_shift_clk_pin_out (sclk_out),
		.ser_shift_clk_pin_oe  (sclk_oe)
	);
	uart_far_end u_far0 (.core_clk(core_clk), .tx(ser_tx_pin[0]), .sclk(sclk_out[0]), .sclk_oe(sclk_oe[0]),
		.rx(ser_rx_pin[0]));
	uart_far_end u_far1 (.core_clk(core_clk), .tx(ser_tx_pin[1]), .sclk(sclk_out[1]), .sclk_oe(sclk_oe[1]),
		.rx(ser_rx_pin[1]));
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic idle_wait();
		do bus(1'b0, 6'h14, 32'h0); while (q[0] !== 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// data, optional parity, stop; lsb first
	function automatic logic [9:0] frame(input int d, input int nb, input int pe, input int odd);
		int p;
		p = odd;
		for (int i = 0; i < nb; i++) p ^= (d >> i) & 1;
		frame = 10'((d & ((1 << nb) - 1)) | (pe ? ((p << nb) | (2 << nb)) : (1 << nb)));
	endfunction
	initial begin
		#1_000_000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		int nb, pe, len, d, g;
		void'($urandom(32'h4327));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		chk(ser_tx_pin, 2'h3);
		chk(sclk_oe, 2'h3);
		bus(1'b1, 6'h38, 32'hffff);
		foreach (ra[i]) rchk(ra[i], 32'h0);
		for (int i = 0; i < 7; i++) begin
			nb = (cfg[i][0] == 1) ? 7 : (cfg[i][0] == 2) ? 8 : 9;
			pe = (cfg[i][0] == 3) ? 0 : cfg[i][1];
			len = (4 << (2 * cfg[i][4])) * (16 * (cfg[i][3] ? cfg[i][3] : 16) + (cfg[i][5] ? 16 - cfg[i][6] : 0));
			d = $urandom() | 1;
			bus(1'b1, 6'h04, 32'(cfg[i][3] | cfg[i][4] << 4 | cfg[i][5] << 6));
			bus(1'b1, 6'h08, 32'(cfg[i][6]));
			bus(1'b1, 6'h00, 32'(cfg[i][0] | cfg[i][1] << 2 | cfg[i][2] << 3 | 32'h60));
			u_far0.nbits = nb + pe + 1;
			exp_q.push_back(frame(d, nb, pe, cfg[i][2]));
			g = u_far0.n_got;
			bus(1'b1, 6'h0c, 32'(d & 32'h1ff));
			rchk(6'h14, 32'h1);
			if (i == 0) bus(1'b1, 6'h0c, 32'h0);
			for (int t = 0; t < 14 * len && u_far0.n_got == g; t++) @(posedge core_clk);
			chk(u_far0.start_len, len);
			chk(u_far0.got, exp_q.pop_front());
			if (i == 0) repeat (12 * len) @(posedge core_clk);
			chk(u_far0.n_got, g + 1);
			idle_wait();
			chk(q, 32'h0);
		end
		bus(1'b1, 6'h24, 32'h1);
		bus(1'b1, 6'h20, 32'h73);
		u_far1.send({frame(32'h0a5, 9, 0, 0), 1'b0}, 11);
		repeat (8) @(posedge core_clk);
		rchk(6'h34, 32'h0);
		u_far1.send({frame(32'h1c3, 9, 0, 0), 1'b0}, 11);
		repeat (8) @(posedge core_clk);
		rchk(6'h34, 32'h22);
		rchk(6'h30, 32'h1c3);
		bus(1'b1, 6'h04, 32'h1);
		bus(1'b1, 6'h00, 32'h66);
		u_far0.send({frame(32'h5a, 8, 1, 1), 1'b0}, 11);
		repeat (8) @(posedge core_clk);
		rchk(6'h14, 32'h2a);
		rchk(6'h10, 32'h15a);
		bus(1'b1, 6'h14, 32'h1c);
		bus(1'b0, 6'h14, 32'h0);
		chk(q & 32'h1f, 32'h0);
		bus(1'b1, 6'h04, 32'h4);
		bus(1'b1, 6'h00, 32'h60);
		d = $urandom() & 32'hff;
		u_far0.sy_out = 8'($urandom());
		u_far0.n_fall = 0;
		bus(1'b1, 6'h0c, 32'(d));
		idle_wait();
		chk(u_far0.sy_in, 32'(d));
		chk(32'(u_far0.t_last - u_far0.t_first), 32'd1120);
		rchk(6'h10, 32'(u_far0.sy_out));
		tally_and_finish();
	end
endmodule
